// file: hw/swcd_pkg.sv
// package: constants for the switch actuator command decoder
package swcd_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_CMD_ID    = 8'h00;
    localparam logic [7:0]  OFS_SWITCH    = 8'h04;
    localparam logic [7:0]  OFS_TIME      = 8'h08;
    localparam logic [7:0]  OFS_MODE      = 8'h0C;
    localparam logic [7:0]  OFS_LOCK      = 8'h10;
    localparam logic [7:0]  OFS_TEACH     = 8'h14;
    localparam logic [7:0]  OFS_GO        = 8'h18;
    localparam logic [7:0]  OFS_STATUS    = 8'h1C;
    localparam logic [7:0]  OFS_REMAIN    = 8'h20;
    // field encodings
    localparam logic [7:0]  CMD_SWITCHING = 8'h01;
    localparam logic [7:0]  CMD_DIMMING   = 8'h02;
    localparam logic        SW_OFF        = 1'b0;
    localparam logic        SW_ON         = 1'b1;
    localparam logic        MODE_DURATION = 1'b0;
    localparam logic        MODE_DELAY    = 1'b1;
    localparam logic        LOCK_UNLOCK   = 1'b0;
    localparam logic        LOCK_LOCK     = 1'b1;
    localparam logic        TEACH_DATA    = 1'b0;
    localparam logic        TEACH_LEARN   = 1'b1;
    // status bit positions
    localparam int          ST_OUT_BIT    = 0;
    localparam int          ST_LOCK_BIT   = 1;
    localparam int          ST_BUSY_BIT   = 2;
    localparam int          ST_REJ_BIT    = 3;
    localparam int          ST_LEARN_BIT  = 4;
    // reset values and response codes
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    // timing
    localparam int          CLK_HZ        = 25_000_000;
    localparam int          TICK_MS       = 100;
    localparam int          TICK_CYCLES   = (CLK_HZ / 1000) * TICK_MS;
    typedef enum logic [1:0] {SWCD_IDLE, SWCD_DURATION, SWCD_DELAY} swcd_state_t;
endpackage

// file: hw/swcd_tick.sv
// tick generator: one-cycle pulse every tick period
module swcd_tick #(
    parameter int TICK_CYCLES = swcd_pkg::TICK_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    output logic      tick_out
);
    import swcd_pkg::*;
    logic [23:0] cnt;
    logic [23:0] next_cnt;
    logic        next_tick;

    always_comb
    begin
        next_tick = 1'b0;
        next_cnt  = cnt + 24'h00_0001;
        if (cnt == 24'(TICK_CYCLES - 1))
        begin
            next_cnt  = 24'h00_0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt      <= 24'h00_0000;
            tick_out <= 1'b0;
        end
        else
        begin
            cnt      <= next_cnt;
            tick_out <= next_tick;
        end
    end

    tick_period_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        tick_out |=> !tick_out) else $error("tick lasted more than one cycle");
endmodule

// file: hw/swcd_timer.sv
// 16-bit tenths-of-second down-counter
module swcd_timer (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        load_in,
    input  wire logic [15:0] value_in,
    input  wire logic        tick_in,
    output logic [15:0]      count_out,
    output logic             expire_out
);
    import swcd_pkg::*;
    logic [15:0] next_count;
    logic        next_expire;

    always_comb
    begin
        next_count  = count_out;
        next_expire = 1'b0;
        if (load_in)
            next_count = value_in;
        else if (tick_in && count_out != 16'h0000)
        begin
            next_count = count_out - 16'h0001;
            if (count_out == 16'h0001)
                next_expire = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_out  <= 16'h0000;
            expire_out <= 1'b0;
        end
        else
        begin
            count_out  <= next_count;
            expire_out <= next_expire;
        end
    end

    expire_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        expire_out |-> count_out == 16'h0000) else $error("expiry with nonzero count");
endmodule

// file: hw/swcd_top.sv
// top: switch actuator command decoder with AXI4-Lite registers
// Notes on behaviour
// - identifier 1 selects switching command
// - identifier 2 selects dimming, field two switches
// - switch field: 0 off, 1 on
// - time in tenths, zero means none
// - duration mode: apply now, revert later
// - delay mode: apply after time elapses
// - lock for time, or forever; 0 unlocks
// - locked: reject all except unlock; teach-in still learns
// - teach-in flag: 0 data, 1 learning
// - flag bits numbered from least significant
module swcd_top #(
    parameter int TICK_CYCLES = swcd_pkg::TICK_CYCLES
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic             switch_out,
    output logic             locked_out,
    output logic             learn_pulse_out
);
    import swcd_pkg::*;

    // ==========================================================
    // command field registers
    logic [7:0]  command_identifier;
    logic        switch_command_field;
    logic [15:0] time_field;
    logic        exec_mode;
    logic        lock_field;
    logic        teach_in;
    logic [7:0]  next_command_identifier;
    logic        next_switch_command_field;
    logic [15:0] next_time_field;
    logic        next_exec_mode;
    logic        next_lock_field;
    logic        next_teach_in;

    // ==========================================================
    // bus write channel
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic [7:0]  next_aw_addr;
    logic        next_w_held;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        wr_fire;
    logic        go;

    assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
    assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
    assign wr_fire           = aw_held && w_held && !s_axi_bvalid_out;
    assign go                = wr_fire && aw_addr == OFS_GO && w_strb[0] && w_data[0];

    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid_out;
        next_bresp   = s_axi_bresp_out;
        next_command_identifier   = command_identifier;
        next_switch_command_field = switch_command_field;
        next_time_field           = time_field;
        next_exec_mode            = exec_mode;
        next_lock_field           = lock_field;
        next_teach_in             = teach_in;
        if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_in;
            next_w_strb = s_axi_wstrb_in;
        end
        if (s_axi_bvalid_out && s_axi_bready_in)
            next_bvalid = 1'b0;
        if (wr_fire)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            unique case (aw_addr)
                OFS_CMD_ID:
                    if (w_strb[0]) next_command_identifier = w_data[7:0];
                OFS_SWITCH:
                    if (w_strb[0]) next_switch_command_field = w_data[0];
                OFS_TIME:
                begin
                    if (w_strb[0]) next_time_field[7:0]  = w_data[7:0];
                    if (w_strb[1]) next_time_field[15:8] = w_data[15:8];
                end
                OFS_MODE:
                    if (w_strb[0]) next_exec_mode = w_data[0];
                OFS_LOCK:
                    if (w_strb[0]) next_lock_field = w_data[0];
                OFS_TEACH:
                    if (w_strb[0]) next_teach_in = w_data[0];
                OFS_GO, OFS_STATUS, OFS_REMAIN:
                    next_bresp = RESP_OKAY;
                default:
                    next_bresp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            aw_held  <= 1'b0;
            aw_addr  <= 8'h00;
            w_held   <= 1'b0;
            w_data   <= RST_ZERO;
            w_strb   <= 4'h0;
            s_axi_bvalid_out     <= 1'b0;
            s_axi_bresp_out      <= RESP_OKAY;
            command_identifier   <= 8'h00;
            switch_command_field <= SW_OFF;
            time_field           <= 16'h0000;
            exec_mode            <= MODE_DURATION;
            lock_field           <= LOCK_UNLOCK;
            teach_in             <= TEACH_DATA;
        end
        else
        begin
            aw_held  <= next_aw_held;
            aw_addr  <= next_aw_addr;
            w_held   <= next_w_held;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            s_axi_bvalid_out     <= next_bvalid;
            s_axi_bresp_out      <= next_bresp;
            command_identifier   <= next_command_identifier;
            switch_command_field <= next_switch_command_field;
            time_field           <= next_time_field;
            exec_mode            <= next_exec_mode;
            lock_field           <= next_lock_field;
            teach_in             <= next_teach_in;
        end
    end

    // ==========================================================
    // timers
    logic        tick;
    logic        act_load;
    logic        lock_load;
    logic [15:0] act_count;
    logic [15:0] lock_count;
    logic        act_expire;
    logic        lock_expire;

    swcd_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .tick_out    (tick)
    );

    swcd_timer u_act_timer (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .load_in     (act_load),
        .value_in    (time_field),
        .tick_in     (tick),
        .count_out   (act_count),
        .expire_out  (act_expire)
    );

    swcd_timer u_lock_timer (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .load_in     (lock_load),
        .value_in    (time_field),
        .tick_in     (tick),
        .count_out   (lock_count),
        .expire_out  (lock_expire)
    );

    // ==========================================================
    // command execution
    swcd_state_t state;
    swcd_state_t next_state;
    logic        pending_value;
    logic        next_pending_value;
    logic        next_switch;
    logic        next_locked;
    logic        rejected;
    logic        next_rejected;
    logic        next_learn;
    logic        known_cmd;
    logic        accept;

    assign known_cmd = command_identifier == CMD_SWITCHING
                    || command_identifier == CMD_DIMMING;
    assign accept    = go && !teach_in && known_cmd
                    && (!locked_out || lock_field == LOCK_UNLOCK);
    assign act_load  = accept && lock_field == LOCK_UNLOCK && time_field != 16'h0000;
    assign lock_load = accept && lock_field == LOCK_LOCK;

    always_comb
    begin
        next_state         = state;
        next_switch        = switch_out;
        next_pending_value = pending_value;
        next_locked        = locked_out;
        next_rejected      = rejected;
        next_learn         = go && teach_in == TEACH_LEARN;
        if (lock_expire && locked_out)
            next_locked = 1'b0;
        if (act_expire)
        begin
            unique case (state)
                SWCD_DURATION: next_switch = pending_value;
                SWCD_DELAY:    next_switch = pending_value;
                SWCD_IDLE:     next_switch = switch_out;
            endcase
            next_state = SWCD_IDLE;
        end
        if (go && !teach_in && !accept)
            next_rejected = 1'b1;
        else if (accept)
            next_rejected = 1'b0;
        if (accept)
        begin
            if (lock_field == LOCK_LOCK)
                next_locked = 1'b1;
            else
            begin
                next_locked = 1'b0;
                if (time_field == 16'h0000)
                begin
                    next_switch = switch_command_field;
                    next_state  = SWCD_IDLE;
                end
                else if (exec_mode == MODE_DURATION)
                begin
                    next_switch        = switch_command_field;
                    next_pending_value = !switch_command_field;
                    next_state         = SWCD_DURATION;
                end
                else
                begin
                    next_switch        = switch_out;                   // drops a pending revert
                    next_pending_value = switch_command_field;
                    next_state         = SWCD_DELAY;
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state           <= SWCD_IDLE;
            switch_out      <= SW_OFF;
            pending_value   <= SW_OFF;
            locked_out      <= 1'b0;
            rejected        <= 1'b0;
            learn_pulse_out <= 1'b0;
        end
        else
        begin
            state           <= next_state;
            switch_out      <= next_switch;
            pending_value   <= next_pending_value;
            locked_out      <= next_locked;
            rejected        <= next_rejected;
            learn_pulse_out <= next_learn;
        end
    end

    // ==========================================================
    // bus read channel
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        next_rvalid;

    assign s_axi_arready_out = !s_axi_rvalid_out;

    always_comb
    begin
        status_word               = RST_ZERO;
        status_word[ST_OUT_BIT]   = switch_out;
        status_word[ST_LOCK_BIT]  = locked_out;
        status_word[ST_BUSY_BIT]  = state != SWCD_IDLE;
        status_word[ST_REJ_BIT]   = rejected;
        status_word[ST_LEARN_BIT] = teach_in;
        next_rdata  = s_axi_rdata_out;
        next_rresp  = s_axi_rresp_out;
        next_rvalid = s_axi_rvalid_out;
        if (s_axi_rvalid_out && s_axi_rready_in)
            next_rvalid = 1'b0;
        if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            unique case (s_axi_araddr_in)
                OFS_CMD_ID: next_rdata = {24'h00_0000, command_identifier};
                OFS_SWITCH: next_rdata = {31'h0000_0000, switch_command_field};
                OFS_TIME:   next_rdata = {16'h0000, time_field};
                OFS_MODE:   next_rdata = {31'h0000_0000, exec_mode};
                OFS_LOCK:   next_rdata = {31'h0000_0000, lock_field};
                OFS_TEACH:  next_rdata = {31'h0000_0000, teach_in};
                OFS_GO:     next_rdata = RST_ZERO;
                OFS_STATUS: next_rdata = status_word;
                OFS_REMAIN: next_rdata = {lock_count, act_count};
                default:
                begin
                    next_rdata = RST_ZERO;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_rdata_out  <= RST_ZERO;
            s_axi_rresp_out  <= RESP_OKAY;
            s_axi_rvalid_out <= 1'b0;
        end
        else
        begin
            s_axi_rdata_out  <= next_rdata;
            s_axi_rresp_out  <= next_rresp;
            s_axi_rvalid_out <= next_rvalid;
        end
    end

    // ==========================================================
    // checks
    lock_blocks_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        locked_out && go && lock_field == LOCK_LOCK |=> $stable(switch_out)) else $error("locked switch changed");
    duration_apply_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        accept && !lock_field && exec_mode == MODE_DURATION && time_field != 16'h0000
        |=> switch_out == $past(switch_command_field)) else $error("duration not applied at once");
    delay_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        accept && !lock_field && exec_mode == MODE_DELAY && time_field != 16'h0000
        |=> $stable(switch_out)) else $error("delay applied early");
    delay_fire_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        state == SWCD_DELAY && act_expire && !accept |=> switch_out == $past(pending_value))
        else $error("delay did not apply");
    lock_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        lock_load |=> locked_out) else $error("lock not taken");
    unlock_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        accept && lock_field == LOCK_UNLOCK |=> !locked_out) else $error("unlock ignored");
    learn_no_exec_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        go && teach_in |=> learn_pulse_out && $stable(switch_out)) else $error("learn telegram executed");
    unknown_reject_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        go && !teach_in && !known_cmd |=> rejected && $stable(switch_out)) else $error("bad id accepted");
    bresp_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out) else $error("bvalid dropped");
    duration_cov: cover property (@(posedge core_clk_in) state == SWCD_DURATION ##1 state == SWCD_IDLE);
    delay_cov: cover property (@(posedge core_clk_in) state == SWCD_DELAY ##1 state == SWCD_IDLE);
    lock_cov: cover property (@(posedge core_clk_in) locked_out && rejected);
    learn_cov: cover property (@(posedge core_clk_in) learn_pulse_out);
endmodule

// file: sim/swcd_actuator_model.sv
// actuator-side model: follows the load output and counts pairing requests
module swcd_actuator_model
(
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic switch_in,
    input  wire logic learn_pulse_in,
    output int        learn_count_out,
    output logic      load_on_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            learn_count_out <= 0;
            load_on_out     <= 1'b0;
        end
        else
        begin
            load_on_out <= switch_in;
            if (learn_pulse_in === 1'b1)
                learn_count_out <= learn_count_out + 1;
        end
    end
endmodule

// file: sim/switch_actuator_command_decoder_tb.sv
// testbench: register-level checks of the switch actuator command decoder
module switch_actuator_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import swcd_pkg::*;
    localparam int TK = 10;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, sw_o, lk_o, learn_o, load_on;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int          mismatches = 0;
    int          n_compared = 0;
    int          learns;
    always #20 core_clk_in = ~core_clk_in;
    swcd_top #(.TICK_CYCLES(TK)) i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .switch_out(sw_o), .locked_out(lk_o), .learn_pulse_out(learn_o));
    swcd_actuator_model i_act (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .switch_in(sw_o),
        .learn_pulse_in(learn_o), .learn_count_out(learns), .load_on_out(load_on));
    // ==========================================
    // reporting
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang(input string nm);
        mismatches++;
        $display("Error %s expected answer seen timeout", nm);
        give_verdict();
    endtask
    // ==========================================
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_in);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge core_clk_in);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid && n < 50);
        rs = bresp;
        bready <= 1'b0;
        if (!bvalid)
            hang("write");
    endtask
    task automatic rd_w(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge core_clk_in);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge core_clk_in);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid && n < 50);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (!rvalid)
            hang("read");
    endtask
    task automatic cmd(input logic [7:0] id, input logic sw, input logic [15:0] t, input logic md,
                       input logic lk, input logic th);
        wr(OFS_CMD_ID, 32'(id));
        wr(OFS_SWITCH, 32'(sw));
        wr(OFS_TIME, 32'(t));
        wr(OFS_MODE, 32'(md));
        wr(OFS_LOCK, 32'(lk));
        wr(OFS_TEACH, 32'(th));
        wr(OFS_GO, 32'h0000_0001);
    endtask
    function automatic logic [31:0] st(input int o, input int l, input int b, input int r, input int t);
        return 32'((o << ST_OUT_BIT) | (l << ST_LOCK_BIT) | (b << ST_BUSY_BIT) | (r << ST_REJ_BIT) | (t << ST_LEARN_BIT));
    endfunction
    task automatic chk_st(input logic [31:0] e);
        rd_w(OFS_STATUS);
        chk("status", e, rd);
    endtask
    // waits for a level; counts edges so early expiry is caught too
    task automatic wait_lvl(input bit lk, input logic e, input int lo, input int hi);
        int n;
        n = 0;
        while (((lk ? lk_o : sw_o) !== e) && n < hi)
        begin
            @(posedge core_clk_in);
            n++;
        end
        if (n >= hi)
            hang("timer expiry");
        chk("expiry not early", 32'h0000_0001, 32'(n >= lo));
    endtask
    // ==========================================
    // scenarios
    initial
    begin
        repeat (12) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        chk_st(RST_ZERO);
        rd_w(8'h24);
        chk("unmapped read resp", 32'(RESP_SLVERR), 32'(rs));
        chk("unmapped read data", RST_ZERO, rd);
        wr(8'h24, 32'hFFFF_FFFF);
        chk("unmapped write resp", 32'(RESP_SLVERR), 32'(rs));
        wr(OFS_TIME, 32'h0000_FFFF);
        rd_w(OFS_TIME);
        chk("time field max", 32'h0000_FFFF, rd);
        cmd(CMD_SWITCHING, SW_ON, 16'h0000, MODE_DURATION, LOCK_UNLOCK, TEACH_DATA);
        chk("switch on", 32'(SW_ON), 32'(sw_o));
        repeat (40) @(posedge core_clk_in);
        chk("no revert without time", 32'(SW_ON), 32'(sw_o));
        chk("load on", 32'(SW_ON), 32'(load_on));
        cmd(CMD_DIMMING, SW_OFF, 16'h0000, MODE_DURATION, LOCK_UNLOCK, TEACH_DATA);
        chk("dimming off", 32'(SW_OFF), 32'(sw_o));
        cmd(CMD_SWITCHING, SW_ON, 16'h0003, MODE_DURATION, LOCK_UNLOCK, TEACH_DATA);
        chk("duration applies now", 32'(SW_ON), 32'(sw_o));
        chk_st(st(1, 0, 1, 0, 0));
        wait_lvl(1'b0, SW_OFF, 15, 45);
        cmd(CMD_SWITCHING, SW_ON, 16'h0003, MODE_DELAY, LOCK_UNLOCK, TEACH_DATA);
        chk("delay withholds", 32'(SW_OFF), 32'(sw_o));
        wait_lvl(1'b0, SW_ON, 15, 45);
        chk_st(st(1, 0, 0, 0, 0));
        cmd(8'h03, SW_OFF, 16'h0000, MODE_DURATION, LOCK_UNLOCK, TEACH_DATA);
        chk_st(st(1, 0, 0, 1, 0));
        cmd(CMD_SWITCHING, SW_OFF, 16'h0000, MODE_DURATION, LOCK_LOCK, TEACH_DATA);
        repeat (40) @(posedge core_clk_in);
        chk("lock without time", 32'(LOCK_LOCK), 32'(lk_o));
        cmd(CMD_SWITCHING, SW_OFF, 16'h0000, MODE_DURATION, LOCK_LOCK, TEACH_DATA);
        chk_st(st(1, 1, 0, 1, 0));
        cmd(CMD_SWITCHING, SW_OFF, 16'h0000, MODE_DURATION, LOCK_UNLOCK, TEACH_DATA);
        chk("unlock ends lock", 32'(LOCK_UNLOCK), 32'(lk_o));
        chk("unlock executes", 32'(SW_OFF), 32'(sw_o));
        cmd(CMD_SWITCHING, SW_OFF, 16'h0002, MODE_DURATION, LOCK_LOCK, TEACH_DATA);
        rd_w(OFS_REMAIN);
        chk("lock count loaded", 32'h0000_0001, 32'(rd[31:16] != 0 && rd[31:16] <= 16'h0002));
        wait_lvl(1'b1, LOCK_UNLOCK, 8, 40);
        cmd(CMD_SWITCHING, SW_ON, 16'h0000, MODE_DURATION, LOCK_UNLOCK, TEACH_LEARN);
        chk("teach not executed", 32'(SW_OFF), 32'(sw_o));
        @(posedge core_clk_in);
        chk("learn pulses", 32'h0000_0001, 32'(learns));
        chk_st(st(0, 0, 0, 0, 1));
        give_verdict();
    end
endmodule
